// ---- include/tstc_pkg.sv ----
// Constants, offsets and types shared by the timing source and time capture block.
// Assumes a 10 MHz system clock and a simple single-cycle register port.
package tstc_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [5:0] OFS_DEMAND_TRIG = 6'h00;
  localparam logic [5:0] OFS_EVENT_TRIG = 6'h04;
  localparam logic [5:0] OFS_UNLOCK = 6'h08;
  localparam logic [5:0] OFS_CONTROL = 6'h10;
  localparam logic [5:0] OFS_INTSTAT = 6'h1C;
  localparam logic [5:0] OFS_MAJOR_LOAD = 6'h28;
  localparam logic [5:0] OFS_RTC_SYNC = 6'h2C;
  localparam logic [5:0] OFS_SNAP_BASE = 6'h30;
  localparam logic [5:0] OFS_SNAP_MASK = 6'h30;

  // ****************************************
  // Control and status field positions
  // ****************************************
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_CODE_LEVEL_SHIFTED_CODE_INPUT = 3;
  localparam int CTL_OSC_EXT = 4;
  localparam int CTL_DISC_EN = 5;
  localparam int CTL_JAM_EN = 6;
  localparam int CTL_EVT_EN = 7;
  localparam int CTL_EVT_PERIODIC = 8;
  localparam int CTL_EVT_FALLING = 9;
  localparam int CTL_LOCKOUT_EN = 10;
  localparam int CTL_WIDTH = 11;
  localparam int ST_EVENT = 0;
  localparam int ST_LOCKED = 8;
  localparam int ST_REF_OK = 9;
  localparam int ST_HELD = 10;
  localparam int ST_MODE_BAD = 11;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 11'h000;

  // ****************************************
  // Timing source mode codes
  // ****************************************
  localparam logic [2:0] MODE_TCODE = 3'h0;
  localparam logic [2:0] MODE_FREE = 3'h1;
  localparam logic [2:0] MODE_EXT_PPS = 3'h2;
  localparam logic [2:0] MODE_RTC = 3'h3;
  localparam logic [2:0] MODE_GNSS = 3'h6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int US_PER_SEC = 1000000;
  localparam logic [3:0] HNS_MAX = 4'(CYC_PER_US - 1);
  localparam logic [19:0] US_MAX = 20'(US_PER_SEC - 1);
  localparam logic [19:0] US_HALF = 20'(US_PER_SEC / 2);
  localparam logic [19:0] JAM_LIMIT_US = 20'h0_0064;
  localparam logic [1:0] MISS_LIMIT = 2'h2;
  localparam logic [15:0] TRIM_MID = 16'h8000;

  // Discipline loop states
  typedef enum logic [2:0] {
    DSC_IDLE = 3'b001,
    DSC_TRACK = 3'b010,
    DSC_LOCKED = 3'b100
  } tstc_dsc_t;

endpackage

// ---- include/tstc_snap_if.sv ----
// Carrier between the time keeper and the snapshot store.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tstc_snap_if;
  logic cap_demand;
  logic cap_event;
  logic [31:0] now_a;
  logic [31:0] now_b;
  logic [1:0] rd_sel;
  logic [31:0] rd_data;
  modport ctrl(output cap_demand, cap_event, now_a, now_b, rd_sel, input rd_data);
  modport store(input cap_demand, cap_event, now_a, now_b, rd_sel, output rd_data);
endinterface

// ---- hw/tstc_snap_store.sv ----
// Snapshot store: two pairs of 32-bit time words and a registered read port.
// Assumes capture strobes are one-cycle pulses on the system clock.
`timescale 1ns/100ps
module tstc_snap_store
  import tstc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  tstc_snap_if.store snap
);

  logic [31:0] demand_a;
  logic [31:0] demand_b;
  logic [31:0] event_a;
  logic [31:0] event_b;
  logic [31:0] next_rd_data;

  // ****************************************
  // Capture both words of a pair together
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      demand_a <= 32'h0000_0000;
      demand_b <= 32'h0000_0000;
      event_a <= 32'h0000_0000;
      event_b <= 32'h0000_0000;
    end else begin
      if (snap.cap_demand) begin
        demand_a <= snap.now_a;
        demand_b <= snap.now_b;
      end
      if (snap.cap_event) begin
        event_a <= snap.now_a;
        event_b <= snap.now_b;
      end
    end
  end

  // Word select for the read port
  assign next_rd_data = (snap.rd_sel == 2'h0) ? demand_a :
                        (snap.rd_sel == 2'h1) ? demand_b :
                        (snap.rd_sel == 2'h2) ? event_a : event_b;

  // Registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap.rd_data <= 32'h0000_0000;
    end else begin
      snap.rd_data <= next_rd_data;
    end
  end

endmodule // tstc_snap_store

// ---- hw/tstc_top.sv ----
// Timing source selection, oscillator disciplining, board time and snapshots.
// Assumes a 10 MHz MCLK and a same-clock register port from the bus logic.
`timescale 1ns/100ps
module tstc_top
  import tstc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input wire logic EVENT_IN,
  input wire logic PERIODIC_IN,
  input wire logic EXT_PPS,
  input wire logic RTC_PPS,
  input wire logic GNSS_PPS,
  input wire logic AM_CODE_ENV,
  input wire logic LEVEL_SHIFTED_CODE_INPUT,
  input wire logic CODE_FRAME_MARK,
  input wire logic [31:0] REF_MAJOR,
  input wire logic REF_MAJOR_VALID,
  output logic [15:0] OSC_TRIM,
  output logic OSC_SELECT_EXT,
  output logic RTC_LOAD,
  output logic [31:0] RTC_TIME
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int NPIN = 6;
  localparam int PIN_EVENT = 0;
  localparam int PIN_EXT = 1;
  localparam int PIN_RTC = 2;
  localparam int PIN_GNSS = 3;
  localparam int PIN_AM = 4;
  localparam int PIN_LEVEL_SHIFTED_CODE_INPUT = 5;

  tstc_snap_if snap();

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;
  logic periodic_q;
  logic periodic_rise;

  logic [CTL_WIDTH-1:0] control;
  logic [2:0] mode;
  logic [3:0] hns;
  logic [19:0] us;
  logic [31:0] major;
  logic [3:0] next_hns;
  logic [19:0] next_us;
  logic [31:0] next_major;
  logic tick_us;
  logic epoch;

  logic ref_edge;
  logic code_rise;
  logic ref_mode;
  logic ref_ok;
  logic [1:0] miss;
  logic allowed;
  logic early;
  logic in_window;
  logic jam;
  tstc_dsc_t dsc;
  tstc_dsc_t next_dsc;
  logic [15:0] next_trim;

  logic acc;
  logic hit_demand;
  logic hit_event;
  logic hit_unlock;
  logic hit_control;
  logic hit_intstat;
  logic hit_major;
  logic hit_rtc;
  logic hit_snap;
  logic hw_edge;
  logic hw_cap;
  logic held;
  logic evt_flag;
  logic [31:0] status;
  logic [31:0] next_rdata;
  logic [31:0] rdata_q;
  logic snap_rd_q;

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  assign pin_raw = {LEVEL_SHIFTED_CODE_INPUT, AM_CODE_ENV, GNSS_PPS, RTC_PPS,
                    EXT_PPS, EVENT_IN};

  // Two flops before use, third flop for edges; PERIODIC_IN gets one flop, its edge taken from the raw input
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      periodic_q <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      periodic_q <= PERIODIC_IN;
    end
  end

  // Edge pulses
  assign pin_rise = pin_s2 & ~pin_s3;
  assign pin_fall = ~pin_s2 & pin_s3;
  assign periodic_rise = PERIODIC_IN & ~periodic_q;

  // ****************************************
  // Reference selection
  // ****************************************
  assign mode = control[CTL_MODE_LSB +: 3];
  // Code epoch from analog envelope or level-shifted form
  assign code_rise = control[CTL_CODE_LEVEL_SHIFTED_CODE_INPUT] ? pin_rise[PIN_LEVEL_SHIFTED_CODE_INPUT] :
                     pin_rise[PIN_AM];
  // Reference second pulse per mode; reserved codes give none
  assign ref_edge = (mode == MODE_TCODE) ? (code_rise & CODE_FRAME_MARK) :
                    (mode == MODE_EXT_PPS) ? pin_rise[PIN_EXT] :
                    (mode == MODE_RTC) ? pin_rise[PIN_RTC] :
                    (mode == MODE_GNSS) ? pin_rise[PIN_GNSS] :
                    1'b0;
  assign ref_mode = (mode == MODE_TCODE) || (mode == MODE_EXT_PPS) ||
                    (mode == MODE_RTC) || (mode == MODE_GNSS);
  assign allowed = ref_mode & ref_ok & control[CTL_DISC_EN];

  // ****************************************
  // Board time counters
  // ****************************************
  assign tick_us = (hns == HNS_MAX);
  assign epoch = tick_us & (us == US_MAX);
  assign early = (us < US_HALF);
  assign in_window = (us == 20'h0_0000) || (us == US_MAX);
  // Jam when phase is far off and jamming is enabled
  assign jam = ref_edge & ref_mode & control[CTL_JAM_EN] &
               (us > JAM_LIMIT_US) & (us < US_MAX - JAM_LIMIT_US);

  // Next minor time: free counting keeps going with no reference
  assign next_hns = (jam || tick_us) ? 4'h0 : hns + 4'h1;
  assign next_us = jam ? 20'h0_0000 :
                   epoch ? 20'h0_0000 :
                   tick_us ? us + 20'h0_0001 : us;

  // Next major time: host load, reference label, jam, rollover
  assign next_major =
    (REG_WR && hit_major) ? REG_WDATA :
    (ref_edge && REF_MAJOR_VALID &&
     ((mode == MODE_TCODE) || (mode == MODE_GNSS))) ? REF_MAJOR :
    (jam && !early) ? major + 32'h0000_0001 :
    epoch ? major + 32'h0000_0001 : major;

  // Time registers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      hns <= 4'h0;
      us <= 20'h0_0000;
      major <= 32'h0000_0000;
    end else begin
      hns <= next_hns;
      us <= next_us;
      major <= next_major;
    end
  end

  // ****************************************
  // Reference presence watch
  // ****************************************
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_ok <= 1'b0;
      miss <= 2'h0;
    end else if (ref_edge) begin
      ref_ok <= 1'b1;
      miss <= 2'h0;
    end else if (!ref_mode || miss == MISS_LIMIT) begin
      ref_ok <= 1'b0; // Flywheel on when the reference is lost
    end else if (epoch) begin
      miss <= miss + 2'h1;
    end
  end

  // ****************************************
  // Discipline loop
  // ****************************************
  always_comb begin
    next_dsc = dsc;
    case (dsc)
      DSC_IDLE: begin
        if (allowed) begin
          next_dsc = DSC_TRACK;
        end
      end
      DSC_TRACK: begin
        if (!allowed) begin
          next_dsc = DSC_IDLE;
        end else if (ref_edge && in_window) begin
          next_dsc = DSC_LOCKED;
        end
      end
      DSC_LOCKED: begin
        if (!allowed) begin
          next_dsc = DSC_IDLE;
        end else if (ref_edge && !in_window) begin
          next_dsc = DSC_TRACK;
        end
      end
      default: begin
        next_dsc = DSC_IDLE;
      end
    endcase
  end

  // Steer frequency by the sign of the phase error at each reference pulse
  assign next_trim = (dsc == DSC_IDLE || !ref_edge || us == 20'h0_0000) ? OSC_TRIM :
                     early ? OSC_TRIM - 16'h0001 : OSC_TRIM + 16'h0001;

  // Loop state and trim word; trim holds while idle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      dsc <= DSC_IDLE;
      OSC_TRIM <= TRIM_MID;
    end else begin
      dsc <= next_dsc;
      OSC_TRIM <= next_trim;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  assign acc = REG_RD | REG_WR;
  assign hit_demand = acc && (REG_ADDR == OFS_DEMAND_TRIG);
  assign hit_event = acc && (REG_ADDR == OFS_EVENT_TRIG);
  assign hit_unlock = acc && (REG_ADDR == OFS_UNLOCK);
  assign hit_control = (REG_ADDR == OFS_CONTROL);
  assign hit_intstat = (REG_ADDR == OFS_INTSTAT);
  assign hit_major = (REG_ADDR == OFS_MAJOR_LOAD);
  assign hit_rtc = acc && (REG_ADDR == OFS_RTC_SYNC);
  assign hit_snap = (REG_ADDR & OFS_SNAP_MASK) == OFS_SNAP_BASE;

  // Control register
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      control <= CTL_RESET;
    end else if (REG_WR && hit_control) begin
      control <= REG_WDATA[CTL_WIDTH-1:0];
    end
  end

  assign OSC_SELECT_EXT = control[CTL_OSC_EXT];

  // ****************************************
  // Event capture
  // ****************************************
  assign hw_edge = control[CTL_EVT_PERIODIC] ? periodic_rise :
                   control[CTL_EVT_FALLING] ? pin_fall[PIN_EVENT] :
                   pin_rise[PIN_EVENT];
  assign hw_cap = control[CTL_EVT_EN] & hw_edge &
                  ~(control[CTL_LOCKOUT_EN] & held);

  // Held flag and event status; a new capture wins over a clear
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      held <= 1'b0;
      evt_flag <= 1'b0;
    end else begin
      held <= hw_cap | (held & ~hit_unlock);
      evt_flag <= hw_cap | (evt_flag & ~(REG_WR & hit_intstat &
                  REG_WDATA[ST_EVENT]));
    end
  end

  // ****************************************
  // Snapshot store
  // ****************************************
  assign snap.cap_demand = hit_demand;
  assign snap.cap_event = hit_event | hw_cap;
  assign snap.now_a = {8'h00, hns, us};
  assign snap.now_b = major;
  assign snap.rd_sel = REG_ADDR[3:2];

  tstc_snap_store u_store (
    .clk(MCLK),
    .rst_n(RESETN),
    .snap(snap.store)
  );

  // ****************************************
  // Real time clock load
  // ****************************************
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      RTC_LOAD <= 1'b0;
      RTC_TIME <= 32'h0000_0000;
    end else begin
      RTC_LOAD <= hit_rtc;
      if (hit_rtc) begin
        RTC_TIME <= major;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    status = 32'h0000_0000;
    status[ST_EVENT] = evt_flag;
    status[ST_LOCKED] = (dsc == DSC_LOCKED);
    status[ST_REF_OK] = ref_ok;
    status[ST_HELD] = held;
    status[ST_MODE_BAD] = ~ref_mode & (mode != MODE_FREE);
  end

  // Unmapped and write-only offsets read as zero
  assign next_rdata = hit_control ? {{(32 - CTL_WIDTH){1'b0}}, control} :
                      hit_intstat ? status : 32'h0000_0000;

  // Read data is registered, answered one cycle after the read
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 32'h0000_0000;
      snap_rd_q <= 1'b0;
    end else begin
      rdata_q <= next_rdata;
      snap_rd_q <= REG_RD & hit_snap;
    end
  end

  // Snapshot words come straight from the store's read register
  assign REG_RDATA = snap_rd_q ? snap.rd_data : rdata_q;

endmodule // tstc_top

// ---- test/tstc_properties.sv ----
// Concurrent checks on the ports of the timing source and time capture top.
// Assumes one clock, MCLK, and the asynchronous active low reset RESETN.
`timescale 1ns/100ps
module tstc_properties
  import tstc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic [15:0] OSC_TRIM,
  input wire logic OSC_SELECT_EXT,
  input wire logic RTC_LOAD,
  input wire logic [31:0] RTC_TIME
);
  // ****************************************
  // Helper decode and properties
  // ****************************************
  logic acc_rtc;
  logic wr_ctl;
  logic rd_snap;
  logic [2:0] mode_q;
  // Access decode seen from the port side
  assign acc_rtc = (REG_RD || REG_WR) && REG_ADDR == OFS_RTC_SYNC;
  assign wr_ctl = REG_WR && REG_ADDR == OFS_CONTROL;
  assign rd_snap = REG_RD && (REG_ADDR == 6'h30 || REG_ADDR == 6'h38);
  // Mirror of the mode field as last written
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q <= 3'h0;
    end else if (wr_ctl) begin
      mode_q <= REG_WDATA[2:0];
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  rtc_load_pulse_a: assert property (acc_rtc |=> RTC_LOAD)
    else $error("clock load pulse missing after sync access");
  rtc_load_cause_a: assert property (RTC_LOAD |-> $past(acc_rtc))
    else $error("clock load pulse without sync access");
  rtc_time_hold_a: assert property (!acc_rtc |=> $stable(RTC_TIME))
    else $error("clock load time moved without sync access");
  osc_sel_write_a: assert property (wr_ctl |=> OSC_SELECT_EXT == $past(REG_WDATA[4]))
    else $error("oscillator select does not follow control write");
  osc_sel_hold_a: assert property (!wr_ctl |=> $stable(OSC_SELECT_EXT))
    else $error("oscillator select moved without control write");
  free_trim_a: assert property (mode_q == MODE_FREE && $past(mode_q) == MODE_FREE |->
    $stable(OSC_TRIM)) else $error("steering moved in free running mode");
  trim_step_a: assert property (!$stable(OSC_TRIM) |->
    OSC_TRIM == $past(OSC_TRIM) + 16'h0001 || OSC_TRIM == $past(OSC_TRIM) - 16'h0001)
    else $error("steering step is not one");
  snap_format_a: assert property (rd_snap |=> REG_RDATA[31:24] == 8'h00 &&
    REG_RDATA[23:20] <= 4'h9 && REG_RDATA[19:0] <= US_MAX) else $error("minor word out of range");
  cov_demand_c: cover property (REG_WR && REG_ADDR == OFS_DEMAND_TRIG);
  cov_rtc_c: cover property (RTC_LOAD);
  cov_trim_c: cover property (!$stable(OSC_TRIM));
endmodule // tstc_properties

bind tstc_top tstc_properties u_props(.MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
  .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .OSC_TRIM(OSC_TRIM), .OSC_SELECT_EXT(OSC_SELECT_EXT), .RTC_LOAD(RTC_LOAD),
  .RTC_TIME(RTC_TIME));

// ---- test/tstc_ref_model.sv ----
// Timing reference model: second pulses, code envelopes and major time.
// Assumes kick is a one-cycle request made between clock edges.
`timescale 1ns/100ps
module tstc_ref_model #(
  parameter int PULSE_CYC = 8
) (
  input wire logic clk,
  input wire logic kick,
  input wire logic [2:0] src,
  input wire logic [31:0] major,
  output logic ext_pps,
  output logic rtc_pps,
  output logic gnss_pps,
  output logic am_env,
  output logic ls_code,
  output logic frame_mark,
  output logic [31:0] ref_major,
  output logic ref_valid
);
  // ****************************************
  // Pulse shaping
  // ****************************************
  int cnt = 0;
  logic [2:0] sel = 3'h0;
  logic on;
  // A request starts one pulse on the chosen source
  always @(posedge clk) begin
    if (kick && cnt == 0) begin
      cnt <= PULSE_CYC;
      sel <= src;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Pins idle low; major time is only meaningful while marked valid
  assign on = cnt > 0;
  assign ext_pps = on && sel == 3'h0;
  assign rtc_pps = on && sel == 3'h1;
  assign gnss_pps = on && sel == 3'h2;
  assign am_env = on && sel == 3'h3;
  assign ls_code = on && sel == 3'h4;
  assign frame_mark = on;
  assign ref_valid = on;
  assign ref_major = on ? major : ~major; // Released bus shows no stale value
endmodule // tstc_ref_model

// ---- test/testbench.sv ----
// Self-checking bench for the timing source and time capture top.
// Assumes the checker binds itself and the reference model drives the source pins.
`timescale 1ns/100ps
module testbench;
  import tstc_pkg::*;
  // ****************************************
  // Signals, instances and tasks
  // ****************************************
  logic MCLK = 0, RESETN = 0, REG_RD = 0, REG_WR = 0, EVENT_IN = 0, PERIODIC_IN = 0, kick = 0;
  logic [5:0] REG_ADDR = 6'h00;
  logic [31:0] REG_WDATA = 32'h0000_0000, major = 32'h0000_0000, REG_RDATA, REF_MAJOR;
  logic [31:0] RTC_TIME, rd, sa, sb, ev;
  logic [15:0] OSC_TRIM, trim;
  logic EXT_PPS, RTC_PPS, GNSS_PPS, AM_CODE_ENV, LEVEL_SHIFTED_CODE_INPUT, CODE_FRAME_MARK;
  logic REF_MAJOR_VALID, OSC_SELECT_EXT, RTC_LOAD;
  logic [2:0] src = 3'h0;
  int bad_count = 0, comparisons = 0, cycles = 0;
  always #50 MCLK = ~MCLK;
  tstc_top DUT(.MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .EVENT_IN(EVENT_IN),
    .PERIODIC_IN(PERIODIC_IN), .EXT_PPS(EXT_PPS), .RTC_PPS(RTC_PPS), .GNSS_PPS(GNSS_PPS),
    .AM_CODE_ENV(AM_CODE_ENV), .LEVEL_SHIFTED_CODE_INPUT(LEVEL_SHIFTED_CODE_INPUT),
    .CODE_FRAME_MARK(CODE_FRAME_MARK), .REF_MAJOR(REF_MAJOR), .REF_MAJOR_VALID(REF_MAJOR_VALID),
    .OSC_TRIM(OSC_TRIM), .OSC_SELECT_EXT(OSC_SELECT_EXT), .RTC_LOAD(RTC_LOAD),
    .RTC_TIME(RTC_TIME));
  tstc_ref_model REF(.clk(MCLK), .kick(kick), .src(src), .major(major), .ext_pps(EXT_PPS),
    .rtc_pps(RTC_PPS), .gnss_pps(GNSS_PPS), .am_env(AM_CODE_ENV),
    .ls_code(LEVEL_SHIFTED_CODE_INPUT), .frame_mark(CODE_FRAME_MARK), .ref_major(REF_MAJOR),
    .ref_valid(REF_MAJOR_VALID));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One register access; read data is taken after the access edge
  task automatic op(input logic r, input logic w, input logic [5:0] a, input logic [31:0] d);
    @(negedge MCLK);
    REG_RD = r;
    REG_WR = w;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge MCLK);
    REG_RD = 1'b0;
    REG_WR = 1'b0;
    rd = REG_RDATA;
  endtask
  // Minor time in units of one clock cycle
  function automatic int ticks(input logic [31:0] w);
    return int'(w[19:0]) * 10 + int'(w[23:20]);
  endfunction
  task automatic idle(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  // Ask the reference model for one pulse on a source
  task automatic pulse(input logic [2:0] s);
    @(negedge MCLK);
    kick = 1'b1;
    src = s;
    @(negedge MCLK);
    kick = 1'b0;
    idle(40);
  endtask
  // Cycle ceiling against hangs
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h97f8_baa0));
    repeat (6) @(posedge MCLK);
    @(negedge MCLK);
    RESETN = 1'b1;
    chk("reset_outs", 32'h8000_0000, {OSC_TRIM, 14'h0000, OSC_SELECT_EXT, RTC_LOAD});
    chk("reset_rtc_time", 32'h0000_0000, RTC_TIME);
    op(1, 0, 6'h0C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    for (int m = 0; m < 8; m++) begin
      trim = 16'($urandom) & 16'h0030;
      op(0, 1, OFS_CONTROL, {16'h0000, trim} | 32'(m));
      op(1, 0, OFS_CONTROL, 32'h0000_0000);
      chk("control", {16'h0000, trim} | 32'(m), rd);
      chk("osc_sel", 32'(trim[4]), 32'(OSC_SELECT_EXT));
      op(1, 0, OFS_INTSTAT, 32'h0000_0000);
      chk("mode_bad", 32'(!(m inside {0, 1, 2, 3, 6})), 32'(rd[ST_MODE_BAD]));
    end
    // Free running: demand and event pairs against cycle counts
    op(0, 1, OFS_CONTROL, 32'h0000_0021);
    major = $urandom;
    op(0, 1, OFS_MAJOR_LOAD, major);
    op(1, 0, OFS_DEMAND_TRIG, 32'h0000_0000);
    op(1, 0, 6'h30, 32'h0000_0000);
    sa = rd;
    op(0, 1, OFS_DEMAND_TRIG, $urandom);
    op(0, 1, OFS_EVENT_TRIG, $urandom);
    op(1, 0, 6'h30, 32'h0000_0000);
    sb = rd;
    chk("demand_step", 32'h0000_0004, 32'(ticks(sb) - ticks(sa)));
    op(1, 0, 6'h34, 32'h0000_0000);
    chk("demand_major", major, rd);
    op(1, 0, 6'h38, 32'h0000_0000);
    chk("event_step", 32'h0000_0002, 32'(ticks(rd) - ticks(sb)));
    op(1, 0, 6'h3C, 32'h0000_0000);
    chk("event_major", major, rd);
    pulse(3'h0);
    chk("free_trim", 32'h0000_8000, 32'(OSC_TRIM));
    op(1, 0, 6'h30, 32'h0000_0000);
    chk("demand_hold", sb, rd);
    // Periodic rise and demand access in the same cycle
    op(0, 1, OFS_CONTROL, 32'h0000_0181);
    @(negedge MCLK);
    PERIODIC_IN = 1'b1;
    REG_WR = 1'b1;
    REG_ADDR = OFS_DEMAND_TRIG;
    @(negedge MCLK);
    PERIODIC_IN = 1'b0;
    REG_WR = 1'b0;
    for (int i = 0; i < 2; i++) begin
      op(1, 0, 6'h30 + 6'(4 * i), 32'h0000_0000);
      sa = rd;
      op(1, 0, 6'h38 + 6'(4 * i), 32'h0000_0000);
      chk("periodic_snap", sa, rd);
    end
    op(1, 0, OFS_INTSTAT, 32'h0000_0000);
    chk("event_flag", 32'h0000_0001, 32'(rd[ST_EVENT]));
    op(0, 1, OFS_INTSTAT, 32'h0000_0001);
    op(1, 0, OFS_INTSTAT, 32'h0000_0000);
    chk("event_clear", 32'h0000_0000, 32'(rd[ST_EVENT]));
    // Event pin, both edge settings, with lockout
    for (int f = 0; f < 2; f++) begin
      EVENT_IN = f[0];
      op(0, 1, OFS_CONTROL, 32'h0000_0481 | (32'(f) << CTL_EVT_FALLING));
      op(0, 1, OFS_UNLOCK, $urandom);
      @(negedge MCLK);
      EVENT_IN = ~EVENT_IN;
      REG_WR = 1'b1;
      REG_ADDR = OFS_DEMAND_TRIG;
      @(negedge MCLK);
      REG_WR = 1'b0;
      idle(6);
      op(1, 0, 6'h30, 32'h0000_0000);
      sa = rd;
      op(1, 0, 6'h38, 32'h0000_0000);
      ev = rd;
      chk("pin_latency", 32'h1, 32'((ticks(ev) - ticks(sa)) inside {[1:4]}));
      op(0, 1, OFS_UNLOCK, $urandom);
      EVENT_IN = ~EVENT_IN;
      idle(6);
      op(1, 0, 6'h38, 32'h0000_0000);
      chk("wrong_edge", ev, rd);
      EVENT_IN = ~EVENT_IN;
      idle(6);
      op(1, 0, 6'h38, 32'h0000_0000);
      ev = rd;
      EVENT_IN = ~EVENT_IN;
      idle(3);
      EVENT_IN = ~EVENT_IN;
      idle(6);
      op(1, 0, 6'h38, 32'h0000_0000);
      chk("lockout", ev, rd);
      op(1, 0, OFS_INTSTAT, 32'h0000_0000);
      chk("held_flag", 32'h1, 32'(rd[ST_HELD]));
      op(1, 0, OFS_EVENT_TRIG, 32'h0000_0000);
      op(1, 0, 6'h38, 32'h0000_0000);
      chk("req_in_lockout", 32'h1, 32'(ticks(rd) > ticks(ev)));
    end
    // Steering from external and on-board second pulses
    op(0, 1, OFS_CONTROL, 32'h0000_0022);
    repeat (3) pulse(3'h0);
    chk("ext_steer", 32'h1, 32'(OSC_TRIM < 16'h8000));
    trim = OSC_TRIM;
    op(0, 1, OFS_CONTROL, 32'h0000_0023);
    repeat (3) pulse(3'h1);
    chk("rtc_steer", 32'h1, 32'(OSC_TRIM < trim));
    // Jam with steering off: minor time restarts at the pulse, trim holds
    trim = OSC_TRIM;
    op(0, 1, OFS_CONTROL, 32'h0000_0042);
    idle(1100);
    pulse(3'h0);
    op(0, 1, OFS_DEMAND_TRIG, $urandom);
    op(1, 0, 6'h30, 32'h0000_0000);
    chk("jam_phase", 32'h0000_0026, 32'(ticks(rd)));
    chk("steer_off", 32'(trim), 32'(OSC_TRIM));
    // Major time from envelope code, level-shifted code and receiver
    for (int k = 0; k < 3; k++) begin
      major = $urandom;
      op(0, 1, OFS_CONTROL, k == 2 ? 32'h0000_0006 : 32'(k) << CTL_CODE_LEVEL_SHIFTED_CODE_INPUT);
      pulse(k == 2 ? 3'h2 : 3'(k + 3));
      op(0, 1, OFS_DEMAND_TRIG, $urandom);
      op(1, 0, 6'h34, 32'h0000_0000);
      chk("ref_major", major, rd);
    end
    op(0, 1, OFS_RTC_SYNC, $urandom);
    chk("rtc_load", 32'h1, 32'(RTC_LOAD));
    chk("rtc_time", major, RTC_TIME);
    @(negedge MCLK);
    chk("rtc_load_end", 32'h0, 32'(RTC_LOAD));
    close_out();
  end
endmodule // testbench
